// ### logic/ssb_pkg.sv
package ssb_pkg;
    // ==========================================================
    // register map (printed offsets are not all multiples of 4)
    localparam logic [3:0]  IDX_FIRST_CONTROL = 4'h0;
    localparam logic [3:0]  IDX_SECOND_CONTROL = 4'h1;
    localparam logic [3:0]  IDX_FLAG_STATUS   = 4'h3;
    localparam logic [3:0]  IDX_DATA_HIGH     = 4'h4;
    localparam logic [3:0]  IDX_DATA_LOW      = 4'h5;
    localparam logic [3:0]  IDX_DATA_WORD     = 4'h6;
    localparam logic [3:0]  IDX_RX_SHIFT      = 4'h7;
    // ==========================================================
    // field positions
    localparam int POS_RX_COMPLETE   = 7;
    localparam int POS_TX_EMPTY      = 5;
    localparam int POS_MODE_FAULT    = 4;
    localparam int POS_MASTER        = 4;
    localparam int POS_INT_ENABLE    = 7;
    localparam int POS_WIDTH_SELECT  = 6;
    localparam int POS_FAULT_DETECT  = 4;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_FIRST_CONTROL  = 8'h04;
    localparam logic [7:0] RST_SECOND_CONTROL = 8'h00;
    // ==========================================================
    // link timing
    localparam int LINK_PERIOD_NS = 200;
    localparam int PCLK_PERIOD_NS = 25;
    localparam int HALF_BIT_CYCLES = LINK_PERIOD_NS / PCLK_PERIOD_NS / 2;

    typedef struct packed {
        logic rx_complete;
        logic tx_empty;
        logic mode_fault;
    } ssb_flags_t;

    typedef enum logic [1:0] {
        SSB_IDLE  = 2'b00,
        SSB_LOW   = 2'b01,
        SSB_HIGH  = 2'b11,
        SSB_DONE  = 2'b10
    } ssb_state_t;
endpackage

// ### logic/ssb_top.sv
// Chosen here: the APB interface to the registers.
module ssb_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sck_in,
    input  wire logic        ss_n_in,
    input  wire logic        miso_in,
    output logic             sck_out,
    output logic             mosi_out,
    output logic             ss_n_out,
    output logic             irq
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] sck_sync;
    logic [1:0] ss_sync;
    logic [1:0] miso_sync;
    logic       sck_prev;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_sync  <= 2'h0;
            ss_sync   <= 2'h3;
            miso_sync <= 2'h0;
            sck_prev  <= 1'b0;
        end
        else
        begin
            sck_sync  <= {sck_sync[0], sck_in};
            ss_sync   <= {ss_sync[0], ss_n_in};
            miso_sync <= {miso_sync[0], miso_in};
            sck_prev  <= sck_sync[1];
        end
    end
    logic sck_rise;
    assign sck_rise = sck_sync[1] & ~sck_prev;

    // ==========================================================
    // apb decode
    logic       acc;
    logic [3:0] idx;
    logic       mapped;
    assign acc    = psel & penable & pready;
    assign idx    = paddr[5:2];
    assign mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0)
                    && (idx <= ssb_pkg::IDX_RX_SHIFT) && (idx != 4'h2);
    logic wr;
    logic rd;
    assign wr = acc & pwrite & mapped;
    assign rd = acc & ~pwrite & mapped;

    // ==========================================================
    // control registers
    logic [7:0] first_control_register;
    logic [7:0] second_control_register;
    logic       master;
    logic       transfer_width_select;
    logic       mode_fault_detect_enable;
    logic       serial_interrupt_enable;
    assign master                   = first_control_register[ssb_pkg::POS_MASTER];
    assign serial_interrupt_enable  = first_control_register[ssb_pkg::POS_INT_ENABLE];
    assign transfer_width_select    = second_control_register[ssb_pkg::POS_WIDTH_SELECT];
    assign mode_fault_detect_enable = second_control_register[ssb_pkg::POS_FAULT_DETECT];

    logic receive_complete_flag, transmit_empty_flag, mode_fault_flag;
    ssb_pkg::ssb_flags_t flags;
    assign flags = {receive_complete_flag, transmit_empty_flag, mode_fault_flag};
    logic mode_fault_event;
    assign mode_fault_event = master & mode_fault_detect_enable & ~ss_sync[1];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_control_register  <= ssb_pkg::RST_FIRST_CONTROL;
            second_control_register <= ssb_pkg::RST_SECOND_CONTROL;
        end
        else
        begin
            if (wr && idx == ssb_pkg::IDX_FIRST_CONTROL)
                first_control_register <= pwdata[7:0];
            else if (mode_fault_event)
                // fault drops back to slave
                first_control_register[ssb_pkg::POS_MASTER] <= 1'b0;
            if (wr && idx == ssb_pkg::IDX_SECOND_CONTROL)
                second_control_register <= pwdata[7:0];
        end
    end

    // ==========================================================
    // status arming
    logic rx_armed;
    logic tx_armed;
    logic mf_armed;
    logic status_read;
    assign status_read = rd && idx == ssb_pkg::IDX_FLAG_STATUS;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_armed <= 1'b0;
            tx_armed <= 1'b0;
            mf_armed <= 1'b0;
        end
        else if (status_read)
        begin
            rx_armed <= flags.rx_complete;
            tx_armed <= flags.tx_empty;
            mf_armed <= flags.mode_fault;
        end
    end

    // ==========================================================
    // data register access
    logic low_read;
    logic low_write;
    logic high_write;
    assign low_read   = rd && (idx == ssb_pkg::IDX_DATA_LOW || idx == ssb_pkg::IDX_DATA_WORD);
    assign low_write  = wr && (idx == ssb_pkg::IDX_DATA_LOW || idx == ssb_pkg::IDX_DATA_WORD);
    assign high_write = wr && (idx == ssb_pkg::IDX_DATA_HIGH || idx == ssb_pkg::IDX_DATA_WORD);
    logic rx_service;
    logic tx_service;
    assign rx_service = low_read & rx_armed & flags.rx_complete;
    assign tx_service = low_write & tx_armed & flags.tx_empty;

    logic [15:0] tx_buffer;
    logic        tx_pending;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_buffer <= 16'h0000;
        else if (flags.tx_empty)
        begin
            if (high_write)
                tx_buffer[15:8] <= pwdata[15:8] & {8{transfer_width_select}};
            if (wr && idx == ssb_pkg::IDX_DATA_HIGH)
                tx_buffer[15:8] <= pwdata[7:0];
            if (low_write)
                tx_buffer[7:0] <= pwdata[7:0];
        end
    end

    // ==========================================================
    // shifter, master only; one bit per link clock rise
    ssb_pkg::ssb_state_t state;
    logic [15:0] shift_out;
    logic [15:0] shift_in;
    logic [4:0]  bit_cnt;
    logic [4:0]  word_bits;
    logic [3:0]  half_cnt;
    logic        xfer_start;
    logic        xfer_done;
    assign word_bits  = transfer_width_select ? 5'h10 : 5'h08;
    assign xfer_start = (state == ssb_pkg::SSB_IDLE) && tx_pending && master;
    assign xfer_done  = (state == ssb_pkg::SSB_HIGH) && sck_rise && (bit_cnt == word_bits - 5'h01);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_pending <= 1'b0;
        else if (tx_service)
            tx_pending <= 1'b1;
        else if (xfer_start || !master)
            tx_pending <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= ssb_pkg::SSB_IDLE;
            shift_out <= 16'h0000;
            shift_in  <= 16'h0000;
            bit_cnt   <= 5'h00;
            half_cnt  <= 4'h0;
            sck_out   <= 1'b0;
            ss_n_out  <= 1'b1;
            mosi_out  <= 1'b0;
        end
        else if (!master)
        begin
            // fault or slave mode aborts to idle
            state    <= ssb_pkg::SSB_IDLE;
            sck_out  <= 1'b0;
            ss_n_out <= 1'b1;
        end
        else
        begin
            case (state)
                ssb_pkg::SSB_IDLE:
                begin
                    if (xfer_start)
                    begin
                        // 9 low-only write: high byte stays whatever was last there
                        shift_out <= transfer_width_select ? tx_buffer
                                                           : {tx_buffer[7:0], 8'h00};
                        bit_cnt   <= 5'h00;
                        half_cnt  <= 4'h0;
                        ss_n_out  <= 1'b0;
                        state     <= ssb_pkg::SSB_LOW;
                    end
                end
                ssb_pkg::SSB_LOW:
                begin
                    mosi_out <= shift_out[15];
                    half_cnt <= half_cnt + 4'h1;
                    if (half_cnt == 4'(ssb_pkg::HALF_BIT_CYCLES - 1))
                    begin
                        half_cnt <= 4'h0;
                        sck_out  <= 1'b1;
                        state    <= ssb_pkg::SSB_HIGH;
                    end
                end
                ssb_pkg::SSB_HIGH:
                begin
                    // sampling is on synchronised link clock rise
                    if (sck_rise)
                    begin
                        shift_in  <= {shift_in[14:0], miso_sync[1]};
                        shift_out <= {shift_out[14:0], 1'b0};
                        bit_cnt   <= bit_cnt + 5'h01;
                        sck_out   <= 1'b0;
                        state     <= xfer_done ? ssb_pkg::SSB_DONE : ssb_pkg::SSB_LOW;
                    end
                end
                ssb_pkg::SSB_DONE:
                begin
                    ss_n_out <= 1'b1;
                    state    <= ssb_pkg::SSB_IDLE;
                end
                default:
                    state <= ssb_pkg::SSB_IDLE;
            endcase
        end
    end

    logic [15:0] rx_word;
    assign rx_word = transfer_width_select ? {shift_in[14:0], miso_sync[1]}
                                           : {8'h00, shift_in[6:0], miso_sync[1]};

    // ==========================================================
    // receive buffering and flags
    logic [15:0] serial_data_word;
    logic [15:0] held_word;
    logic        held_valid;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_data_word      <= 16'h0000;
            held_word             <= 16'h0000;
            held_valid            <= 1'b0;
            receive_complete_flag <= 1'b0;
        end
        else
        begin
            if (xfer_done && (!flags.rx_complete || rx_service) && !held_valid)
            begin
                serial_data_word      <= rx_word;
                receive_complete_flag <= 1'b1;
            end
            else if (xfer_done)
            begin
                // arrival wins over a clear in the same cycle
                held_word  <= rx_word;
                held_valid <= 1'b1;
            end
            else if (rx_service && held_valid)
            begin
                serial_data_word <= held_word;
                held_valid       <= 1'b0;
            end
            else if (rx_service)
                receive_complete_flag <= 1'b0;
            if (xfer_start && held_valid && flags.rx_complete && !rx_service)
                held_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            transmit_empty_flag <= 1'b1;
        else if (xfer_start)
            transmit_empty_flag <= 1'b1;
        else if (tx_service)
            transmit_empty_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_fault_flag <= 1'b0;
        else if (mode_fault_event)
            mode_fault_flag <= 1'b1;
        else if (wr && idx == ssb_pkg::IDX_FIRST_CONTROL && mf_armed)
            mode_fault_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= flags.mode_fault & serial_interrupt_enable;
    end

    // ==========================================================
    // read mux; data readable any time, meaningful only with flag set
    logic [31:0] next_prdata;
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (idx)
            ssb_pkg::IDX_FIRST_CONTROL:  next_prdata[7:0] = first_control_register;
            ssb_pkg::IDX_SECOND_CONTROL: next_prdata[7:0] = second_control_register;
            ssb_pkg::IDX_FLAG_STATUS:    next_prdata[7:0] = {flags.rx_complete, 1'b0,
                                         flags.tx_empty, flags.mode_fault, 4'h0};
            // low-only read leaves high byte unread and lost
            ssb_pkg::IDX_DATA_HIGH:      next_prdata[7:0] = serial_data_word[15:8];
            ssb_pkg::IDX_DATA_LOW:       next_prdata[7:0] = serial_data_word[7:0];
            ssb_pkg::IDX_DATA_WORD:      next_prdata[15:0] = serial_data_word;
            ssb_pkg::IDX_RX_SHIFT:       next_prdata[0] = held_valid;
            default:                     next_prdata = 32'h0000_0000;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            prdata  <= next_prdata;
            pslverr <= psel & penable & ~pready & ~mapped;
        end
    end

    // ==========================================================
    // checks
    status_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == ssb_pkg::IDX_FLAG_STATUS && !mode_fault_event |=> $stable(flags.mode_fault))
        else $error("status write changed a flag");
    rx_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_done && !flags.rx_complete && !held_valid |=> flags.rx_complete)
        else $error("receive flag not set");
    rx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_service && !xfer_done && !held_valid |=> !flags.rx_complete)
        else $error("receive flag not cleared");
    tx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_service && !xfer_start |=> !flags.tx_empty && tx_pending)
        else $error("transmit flag not cleared");
    tx_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        !flags.tx_empty |=> $stable(tx_buffer))
        else $error("write accepted while full");
    fault_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_fault_event |=> flags.mode_fault ##1 (irq == serial_interrupt_enable))
        else $error("mode fault not reported");
    held_move_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_service && held_valid && !xfer_done && !xfer_start
        |=> flags.rx_complete && serial_data_word == $past(held_word))
        else $error("held word not moved");
    start_next_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_pending && master && state == ssb_pkg::SSB_IDLE |=> !ss_n_out)
        else $error("queued word not started");
endmodule

// ### verification/ssb_remote_slave.sv
// ==========================================================
// remote serial peripheral: answers every frame, msb first
module ssb_remote_slave
(
    input  wire logic        sck,
    input  wire logic        ss_n,
    input  wire logic        mosi,
    input  wire logic        wide,
    output logic             miso,
    output int               words,
    output logic [15:0]      last_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rep_q[$];
    logic [15:0] tx_sh    = 16'h0000;
    logic [15:0] rx_sh    = 16'h0000;
    logic        idle_lvl = 1'b0;
    logic        reload   = 1'b0;
    int          bits     = 0;

    // peek only: a word leaves the queue once its first bit is taken
    function automatic logic [15:0] next_word();
        return (rep_q.size() > 0) ? rep_q[0] : 16'h0000;
    endfunction

    initial words = 0;
    initial last_rx = 16'h0000;
    always @(negedge ss_n)
    begin
        bits = 0;
        tx_sh = next_word();
    end
    // released line shows the inverse of miso as ss_n rises, held until the next release even if the queue changes
    always @(posedge ss_n) idle_lvl = ~miso;
    always @(posedge sck)
    begin
        if (ss_n === 1'b0)
        begin
            rx_sh = {rx_sh[14:0], mosi};
            bits++;
            if (bits == 1 && rep_q.size() > 0)
                void'(rep_q.pop_front());
            if (bits == (wide ? 16 : 8))
            begin
                last_rx = wide ? rx_sh : {8'h00, rx_sh[7:0]};
                bits = 0;
                reload = 1'b1;
                words++;
            end
        end
    end
    // data moves on the falling edge so it is settled at the sampling edge
    always @(negedge sck)
    begin
        if (ss_n === 1'b0)
        begin
            tx_sh = reload ? next_word() : tx_sh << 1;
            reload = 1'b0;
        end
    end
    always_comb miso = ss_n ? idle_lvl : (wide ? tx_sh[15] : tx_sh[7]);
endmodule

// ### verification/tb_spi_status_and_data_buffer.sv
module tb_spi_status_and_data_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ss_n_in = 1'b1, wide = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sck_out, mosi_out, ss_n_out, irq, miso;
    logic [15:0] rx_last;
    int          rx_words, cyc, err_total, cmp_count;
    int          seed = 64101;
    logic [32:0] got;
    logic [32:0] exp_q[$], msk_q[$];
    logic [15:0] tx_q[$];
    logic [7:0]  a, b, c, p1, p2;
    logic [15:0] d1, d2, d3, q1, q2, q3;

    always #12.5 pclk = ~pclk;

    // serial clock looped straight back, as a wire would
    ssb_top i_ssb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck_in(sck_out), .ss_n_in(ss_n_in),
        .miso_in(miso), .sck_out(sck_out), .mosi_out(mosi_out), .ss_n_out(ss_n_out),
        .irq(irq));
    ssb_remote_slave i_ssb_remote_slave (.sck(sck_out), .ss_n(ss_n_out), .mosi(mosi_out),
        .wide(wide), .miso(miso), .words(rx_words), .last_rx(rx_last));

    // ==========================================================
    // checking and closing
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            check({pslverr, prdata} & (msk_q.pop_front() | 33'h100000000), exp_q.pop_front());
    end

    // port updates of count and word may land in either order
    always @(rx_words)
    begin
        #1;
        if (rx_words > 0)
            check({17'h0, rx_last}, (tx_q.size() > 0) ? {17'h0, tx_q.pop_front()} : 33'h1FFFFFFFF);
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // ==========================================================
    // bus master
    task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the bench timeout ends a wait for the slave's answer
        while (pready !== 1'b1)
            @(posedge pclk);
        got = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] idx, input logic [32:0] exp, input logic [32:0] msk);
        exp_q.push_back(exp);
        msk_q.push_back(msk);
        apb(1'b0, idx, 32'h0);
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    // the polling read also arms the transmit-empty clear
    task automatic poll_tx();
        for (int i = 0; i < 200; i++)
        begin
            rd(ssb_pkg::IDX_FLAG_STATUS, 33'h0, 33'h0);
            if (got[ssb_pkg::POS_TX_EMPTY] === 1'b1)
                break;
        end
    endtask

    task automatic wait_done(input int n);
        for (int i = 0; i < 4000; i++)
        begin
            if (rx_words >= n && ss_n_out === 1'b1)
                break;
            @(posedge pclk);
        end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        {a, b, c, p1} = $random(seed);
        {d1, d2} = $random(seed);
        {d3, q1} = $random(seed);
        q3 = 16'($random(seed));
        q2 = ~q3;
        p2 = ~p1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h020, 33'h0B0);
        wr(ssb_pkg::IDX_FLAG_STATUS, 32'hFF);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h020, 33'h0B0);
        rd(4'hA, 33'h100000000, 33'h0FFFFFFFF);
        wr(ssb_pkg::IDX_FIRST_CONTROL, 32'h14);
        // two words queued back to back, a third refused
        i_ssb_remote_slave.rep_q.push_back({8'h00, p1});
        i_ssb_remote_slave.rep_q.push_back({8'h00, p2});
        poll_tx();
        wr(ssb_pkg::IDX_DATA_LOW, 32'(a));
        tx_q.push_back({8'h00, a});
        poll_tx();
        wr(ssb_pkg::IDX_DATA_LOW, 32'(b));
        tx_q.push_back({8'h00, b});
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h000, 33'h020);
        wr(ssb_pkg::IDX_DATA_LOW, 32'(c));
        wait_done(2);
        rd(ssb_pkg::IDX_DATA_LOW, 33'(p1), 33'h0FF);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h0A0, 33'h0B0);
        rd(ssb_pkg::IDX_DATA_LOW, 33'(p1), 33'h0FF);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h080, 33'h080);
        rd(ssb_pkg::IDX_DATA_LOW, 33'(p2), 33'h0FF);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h000, 33'h080);
        // 16-bit words, servicing only after the third frame starts
        wide = 1'b1;
        wr(ssb_pkg::IDX_SECOND_CONTROL, 32'h40);
        i_ssb_remote_slave.rep_q.push_back(q1);
        i_ssb_remote_slave.rep_q.push_back(q2);
        i_ssb_remote_slave.rep_q.push_back(q3);
        poll_tx();
        wr(ssb_pkg::IDX_DATA_HIGH, 32'(d1[15:8]));
        wr(ssb_pkg::IDX_DATA_HIGH, 32'(d1[15:8]));
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h020, 33'h020);
        wr(ssb_pkg::IDX_DATA_LOW, 32'(d1[7:0]));
        tx_q.push_back(d1);
        wait_done(3);
        poll_tx();
        wr(ssb_pkg::IDX_DATA_WORD, 32'(d2));
        tx_q.push_back(d2);
        wait_done(4);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h0A0, 33'h0B0);
        wr(ssb_pkg::IDX_DATA_WORD, 32'(d3));
        tx_q.push_back(d3);
        for (int i = 0; i < 400 && sck_out !== 1'b1; i++)
            @(posedge pclk);
        rd(ssb_pkg::IDX_DATA_HIGH, 33'(q1[15:8]), 33'h0FF);
        rd(ssb_pkg::IDX_DATA_HIGH, 33'(q1[15:8]), 33'h0FF);
        rd(ssb_pkg::IDX_DATA_LOW, 33'(q1[7:0]), 33'h0FF);
        wait_done(5);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h080, 33'h080);
        rd(ssb_pkg::IDX_DATA_LOW, 33'(q3[7:0]), 33'h0FF);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h000, 33'h080);
        // mode fault with interrupt enable, then software clear
        wr(ssb_pkg::IDX_SECOND_CONTROL, 32'h50);
        wr(ssb_pkg::IDX_FIRST_CONTROL, 32'h94);
        @(posedge pclk);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge pclk);
        ss_n_in <= 1'b1;
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h010, 33'h010);
        check(33'(irq), 33'h1);
        wr(ssb_pkg::IDX_FIRST_CONTROL, 32'h94);
        rd(ssb_pkg::IDX_FLAG_STATUS, 33'h000, 33'h010);
        check(33'(irq), 33'h0);
        repeat (8) @(posedge pclk);
        check(33'(tx_q.size()), 33'h0);
        end_of_test();
    end
endmodule
